/* hw/hpsc_pkg.sv */
// constants and types for the host port select and serial control block
// assumes a single clock system domain plus the host-made shift clock
package hpsc_pkg;

   // ----------------------------------------------------------------
   // serial framing
   // ----------------------------------------------------------------
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned BIT_CNT_W     = 3;
   localparam logic [2:0]  BIT_CNT_LAST  = 3'h7;
   localparam logic [2:0]  BIT_CNT_FIRST = 3'h0;
   localparam int unsigned SYNC_STAGES   = 2;

   // ----------------------------------------------------------------
   // header codes (range bit cleared)
   // ----------------------------------------------------------------
   localparam logic [7:0]  HDR_ALT_NI    = 8'h40;
   localparam logic [7:0]  HDR_ALT_IL    = 8'h48;
   localparam logic [7:0]  HDR_CONST     = 8'h43;
   localparam logic [7:0]  HDR_RTW_NI    = 8'h41;
   localparam logic [7:0]  HDR_RTW_IL    = 8'h49;
   localparam int unsigned HDR_RANGE_BIT = 2;
   localparam logic [7:0]  HDR_RANGE_MSK = 8'h04;

   // ----------------------------------------------------------------
   // address byte layout
   // ----------------------------------------------------------------
   localparam int unsigned ADR_RD_BIT    = 7;
   localparam int unsigned ADR_LOW_MSB   = 6;
   localparam int unsigned IND_SEL_BIT   = 0;

   // ----------------------------------------------------------------
   // fifo window for constant address sequences
   // ----------------------------------------------------------------
   localparam logic [7:0]  FIFO_WIN_LO   = 8'h00;
   localparam logic [7:0]  FIFO_WIN_HI   = 8'h1F;
   localparam logic [7:0]  FIFO_WIN_ALT0 = 8'h6A;
   localparam logic [7:0]  FIFO_WIN_ALT1 = 8'h7A;

   // ----------------------------------------------------------------
   // strap input vector positions
   // ----------------------------------------------------------------
   localparam int unsigned STRAP_WR      = 0;
   localparam int unsigned STRAP_RD      = 1;
   localparam int unsigned STRAP_SEL     = 2;
   localparam int unsigned STRAP_LATCH   = 3;
   localparam int unsigned STRAP_INIT    = 4;
   localparam int unsigned STRAP_IND     = 5;
   localparam int unsigned STRAP_W       = 6;

   typedef enum logic [2:0] {
      HPSC_MODE_STROBE,
      HPSC_MODE_NONMUX,
      HPSC_MODE_MUX,
      HPSC_MODE_SERIAL,
      HPSC_MODE_NOHOST
   } hpsc_mode_e;

   typedef enum logic [1:0] {
      HPSC_SEQ_ALT,
      HPSC_SEQ_CONST,
      HPSC_SEQ_RTW
   } hpsc_seq_e;

   typedef enum logic [2:0] {
      HPSC_ST_HDR,
      HPSC_ST_ADDR,
      HPSC_ST_SKIP,
      HPSC_ST_WDATA,
      HPSC_ST_CWRITE,
      HPSC_ST_CREAD,
      HPSC_ST_BAD
   } hpsc_state_e;

endpackage : hpsc_pkg

/* hw/hpsc_serial_ctrl.sv */
// host port select and four wire serial control port
// assumes an outside register file answering reads one sys_clk later
`timescale 1ns/1ps
module hpsc_serial_ctrl
   import hpsc_pkg::*;
(
   // system clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // strap pins and hardware init
   input  wire logic       hw_init_n,
   input  wire logic       strap_wr,
   input  wire logic       strap_rd,
   input  wire logic       strap_sel,
   input  wire logic       strap_latch,
   input  wire logic       indirect_addressing_select,
   // serial port pins
   input  wire logic       shift_clk,
   input  wire logic       select_n,
   input  wire logic       serial_data_in,
   output logic            serial_data_out,
   output logic            serial_data_out_oe,
   // register file side
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wr_data,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   input  wire logic [7:0] reg_rd_data,
   output logic            fifo_ptr_inc,
   // mode outputs
   output hpsc_mode_e      host_mode,
   output logic            mgmt_slave_en,
   // interrupt pin
   input  wire logic       irq_req,
   input  wire logic       irq_active_high,
   output logic            irq_out,
   output logic            irq_oe
);

   // ----------------------------------------------------------------
   // link domain: shift register, bit count, byte toggle
   // ----------------------------------------------------------------
   // select high holds the framing logic in reset, so clock activity
   // is ignored and a partial byte is dropped
   logic       link_rst;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] sh_in_reg, sh_in_next;
   logic       first_reg, first_next;
   logic [7:0] rx_byte_reg, rx_byte_next;
   logic       rx_tgl_reg, rx_tgl_next;
   logic [7:0] tx_sh_reg, tx_sh_next;
   logic       tx_on_reg, tx_on_next;
   logic       out_bit_reg, out_bit_next;
   logic       out_en_reg, out_en_next;
   // system domain read data, quasi static while the host waits
   logic [7:0] tx_byte_reg;
   logic       tx_valid_reg;

   assign link_rst = select_n | rst;

   always_comb
   begin
      bit_cnt_next = bit_cnt_reg + 3'h1;
      sh_in_next   = {sh_in_reg[6:0], serial_data_in};
      first_next   = first_reg;
      rx_byte_next = rx_byte_reg;
      rx_tgl_next  = rx_tgl_reg;
      tx_sh_next   = tx_sh_reg;
      tx_on_next   = tx_on_reg;
      if (bit_cnt_reg == BIT_CNT_FIRST)
      begin
         tx_sh_next = tx_byte_reg;
         tx_on_next = tx_valid_reg & ~first_reg;
      end
      if (bit_cnt_reg == BIT_CNT_LAST)
      begin
         rx_byte_next = sh_in_next;
         rx_tgl_next  = ~rx_tgl_reg;
         first_next   = 1'b0;
      end
   end

   always_ff @(posedge shift_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         bit_cnt_reg <= BIT_CNT_FIRST;
         sh_in_reg   <= 8'h00;
         first_reg   <= 1'b1;
         tx_sh_reg   <= 8'h00;
         tx_on_reg   <= 1'b0;
      end
      else
      begin
         bit_cnt_reg <= bit_cnt_next;
         sh_in_reg   <= sh_in_next;
         first_reg   <= first_next;
         tx_sh_reg   <= tx_sh_next;
         tx_on_reg   <= tx_on_next;
      end
   end

   // toggle and byte survive select so the other domain never sees a
   // spurious event when a frame is cut short
   always_ff @(posedge shift_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_byte_reg <= 8'h00;
         rx_tgl_reg  <= 1'b0;
      end
      else
      begin
         rx_byte_reg <= rx_byte_next;
         rx_tgl_reg  <= rx_tgl_next;
      end
   end

   // ----------------------------------------------------------------
   // link domain: output on falling edges
   // ----------------------------------------------------------------
   always_comb
   begin
      out_bit_next = tx_sh_reg[3'h7 - bit_cnt_reg];
      out_en_next  = tx_on_reg & (bit_cnt_reg != BIT_CNT_FIRST);
   end

   always_ff @(negedge shift_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         out_bit_reg <= 1'b0;
         out_en_reg  <= 1'b0;
      end
      else
      begin
         out_bit_reg <= out_bit_next;
         out_en_reg  <= out_en_next;
      end
   end

   // msb is presented during the gap before the slot, so the host's
   // first rising edge already sees it; later bits follow falling edges
   always_comb
   begin
      if (bit_cnt_reg == BIT_CNT_FIRST)
      begin
         serial_data_out    = tx_byte_reg[7];
         serial_data_out_oe = ~select_n & tx_valid_reg & ~first_reg;
      end
      else
      begin
         serial_data_out    = out_bit_reg;
         serial_data_out_oe = ~select_n & out_en_reg;
      end
   end

   // ----------------------------------------------------------------
   // crossings into sys_clk
   // ----------------------------------------------------------------
   logic [STRAP_W-1:0] strap_s;
   logic [1:0]         link_s;
   logic               rx_ref_reg, rx_ref_next;
   logic               byte_evt;
   logic               sel_idle;

   // init enters active high so a freshly reset synchroniser reads idle
   hpsc_sync2 #(.WIDTH(STRAP_W)) u_sync_strap (
      .clk (sys_clk),
      .rst (rst),
      .d   ({indirect_addressing_select, ~hw_init_n, strap_latch,
             strap_sel, strap_rd, strap_wr}),
      .q   (strap_s)
   );

   hpsc_sync2 #(.WIDTH(2)) u_sync_link (
      .clk (sys_clk),
      .rst (rst),
      .d   ({select_n, rx_tgl_reg}),
      .q   (link_s)
   );

   assign sel_idle = link_s[1];
   assign byte_evt = (link_s[0] != rx_ref_reg) & (host_mode == HPSC_MODE_SERIAL);

   // ----------------------------------------------------------------
   // strap evaluation
   // ----------------------------------------------------------------
   hpsc_mode_e mode_reg, mode_next;
   logic       latch_prev_reg;
   // latch edges are ignored until the synchroniser has flushed its reset value
   logic [2:0] prime_reg, prime_next;

   always_comb
   begin
      mode_next  = mode_reg;
      prime_next = {prime_reg[1:0], 1'b1};
      if (strap_s[STRAP_INIT])
      begin
         if (strap_s[STRAP_WR] & strap_s[STRAP_RD])
         begin
            mode_next = strap_s[STRAP_LATCH] ? HPSC_MODE_STROBE : HPSC_MODE_NONMUX;
         end
         else if (strap_s[STRAP_SEL])
         begin
            mode_next = HPSC_MODE_SERIAL;
         end
         else
         begin
            mode_next = HPSC_MODE_NOHOST;
         end
      end
      // only a new init can leave the multiplexed bus again
      if (prime_reg[2] && (strap_s[STRAP_LATCH] != latch_prev_reg) &&
          (mode_next == HPSC_MODE_STROBE || mode_next == HPSC_MODE_NONMUX))
      begin
         mode_next = HPSC_MODE_MUX;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_reg       <= HPSC_MODE_NONMUX;
         latch_prev_reg <= 1'b0;
         prime_reg      <= 3'h0;
      end
      else
      begin
         mode_reg       <= mode_next;
         latch_prev_reg <= strap_s[STRAP_LATCH];
         prime_reg      <= prime_next;
      end
   end

   assign host_mode     = mode_reg;
   assign mgmt_slave_en = (mode_reg == HPSC_MODE_NOHOST);

   // ----------------------------------------------------------------
   // sequence engine
   // ----------------------------------------------------------------
   hpsc_state_e state_reg, state_next;
   hpsc_seq_e   seq_reg, seq_next;
   logic        ilv_reg, ilv_next;
   logic        range_reg, range_next;
   logic [7:0]  addr_reg, addr_next;
   logic [7:0]  ptr_reg, ptr_next;
   logic        rd_go_reg, rd_go_next;
   logic        rd_wait_reg, rd_wait_next;
   logic [7:0]  tx_byte_next;
   logic        tx_valid_next;
   logic [7:0]  wdata_reg, wdata_next;
   logic        wr_en_reg, wr_en_next;
   logic        rd_en_reg;
   logic        inc_reg, inc_next;
   logic        ind_s;
   logic [7:0]  hdr_base;
   logic [7:0]  abyte;
   logic        in_fifo;

   assign ind_s    = strap_s[STRAP_IND];
   assign hdr_base = rx_byte_reg & ~HDR_RANGE_MSK;
   assign abyte    = {range_reg, rx_byte_reg[ADR_LOW_MSB:0]};
   assign in_fifo  = ((addr_reg >= FIFO_WIN_LO) && (addr_reg <= FIFO_WIN_HI)) ||
                     (addr_reg == FIFO_WIN_ALT0) || (addr_reg == FIFO_WIN_ALT1);

   always_comb
   begin
      state_next    = state_reg;
      seq_next      = seq_reg;
      ilv_next      = ilv_reg;
      range_next    = range_reg;
      addr_next     = addr_reg;
      ptr_next      = ptr_reg;
      rd_go_next    = 1'b0;
      rd_wait_next  = rd_en_reg;
      tx_byte_next  = tx_byte_reg;
      tx_valid_next = tx_valid_reg;
      wdata_next    = wdata_reg;
      wr_en_next    = 1'b0;
      inc_next      = 1'b0;
      if (byte_evt)
      begin
         tx_valid_next = 1'b0;
         case (state_reg)
            HPSC_ST_HDR:
            begin
               range_next = rx_byte_reg[HDR_RANGE_BIT];
               state_next = HPSC_ST_ADDR;
               if (hdr_base == HDR_ALT_NI || hdr_base == HDR_ALT_IL)
               begin
                  seq_next = HPSC_SEQ_ALT;
                  ilv_next = (hdr_base == HDR_ALT_IL);
               end
               else if (hdr_base == HDR_CONST)
               begin
                  seq_next = HPSC_SEQ_CONST;
                  ilv_next = 1'b0;
               end
               else if (hdr_base == HDR_RTW_NI || hdr_base == HDR_RTW_IL)
               begin
                  seq_next = HPSC_SEQ_RTW;
                  ilv_next = (hdr_base == HDR_RTW_IL);
               end
               else
               begin
                  state_next = HPSC_ST_BAD;
               end
            end
            HPSC_ST_ADDR:
            begin
               addr_next = abyte;
               if (rx_byte_reg[ADR_RD_BIT])
               begin
                  rd_go_next = 1'b1;
                  if (seq_reg == HPSC_SEQ_CONST)
                  begin
                     state_next = HPSC_ST_CREAD;
                  end
                  else
                  begin
                     state_next = ilv_reg ? HPSC_ST_ADDR : HPSC_ST_SKIP;
                  end
               end
               else if (seq_reg == HPSC_SEQ_ALT)
               begin
                  state_next = HPSC_ST_WDATA;
               end
               else
               begin
                  state_next = HPSC_ST_CWRITE;
               end
            end
            HPSC_ST_SKIP:
            begin
               state_next = HPSC_ST_ADDR;
            end
            HPSC_ST_WDATA, HPSC_ST_CWRITE:
            begin
               if (state_reg == HPSC_ST_WDATA)
               begin
                  state_next = HPSC_ST_ADDR;
               end
               if (ind_s && !addr_reg[IND_SEL_BIT])
               begin
                  ptr_next = rx_byte_reg;
               end
               else
               begin
                  wdata_next = rx_byte_reg;
                  wr_en_next = 1'b1;
               end
               inc_next = (seq_reg == HPSC_SEQ_CONST) & in_fifo;
            end
            HPSC_ST_CREAD:
            begin
               inc_next   = in_fifo;
               rd_go_next = 1'b1;
            end
            default:
            begin
               state_next = HPSC_ST_BAD;
            end
         endcase
      end
      else if (sel_idle)
      begin
         state_next    = HPSC_ST_HDR;
         tx_valid_next = 1'b0;
         rd_go_next    = 1'b0;
      end
      // a reply beats a byte event in the same cycle; one for a closed frame is dropped
      if (rd_wait_reg)
      begin
         tx_byte_next  = (ind_s && !addr_reg[IND_SEL_BIT]) ? ptr_reg : reg_rd_data;
         tx_valid_next = ~sel_idle;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg    <= HPSC_ST_HDR;
         seq_reg      <= HPSC_SEQ_ALT;
         ilv_reg      <= 1'b0;
         range_reg    <= 1'b0;
         addr_reg     <= 8'h00;
         ptr_reg      <= 8'h00;
         rd_go_reg    <= 1'b0;
         rd_en_reg    <= 1'b0;
         rd_wait_reg  <= 1'b0;
         tx_byte_reg  <= 8'h00;
         tx_valid_reg <= 1'b0;
         wdata_reg    <= 8'h00;
         wr_en_reg    <= 1'b0;
         inc_reg      <= 1'b0;
         rx_ref_reg   <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         seq_reg      <= seq_next;
         ilv_reg      <= ilv_next;
         range_reg    <= range_next;
         addr_reg     <= addr_next;
         ptr_reg      <= ptr_next;
         rd_go_reg    <= rd_go_next;
         rd_en_reg    <= rd_go_reg; // read issued after any fifo advance
         rd_wait_reg  <= rd_wait_next;
         tx_byte_reg  <= tx_byte_next;
         tx_valid_reg <= tx_valid_next;
         wdata_reg    <= wdata_next;
         wr_en_reg    <= wr_en_next;
         inc_reg      <= inc_next;
         rx_ref_reg   <= link_s[0];
      end
   end

   assign reg_addr     = (ind_s && addr_reg[IND_SEL_BIT]) ? ptr_reg : addr_reg;
   assign reg_wr_data  = wdata_reg;
   assign reg_wr_en    = wr_en_reg;
   assign reg_rd_en    = rd_en_reg & ~(ind_s & ~addr_reg[IND_SEL_BIT]);
   assign fifo_ptr_inc = inc_reg;

   // ----------------------------------------------------------------
   // interrupt pin
   // ----------------------------------------------------------------
   // low active form is open drain, high active form is push-pull
   logic irq_out_reg, irq_out_next;
   logic irq_oe_reg, irq_oe_next;

   always_comb
   begin
      irq_out_next = irq_active_high & irq_req;
      irq_oe_next  = irq_active_high | irq_req;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_out_reg <= 1'b0;
         irq_oe_reg  <= 1'b0;
      end
      else
      begin
         irq_out_reg <= irq_out_next;
         irq_oe_reg  <= irq_oe_next;
      end
   end

   assign irq_out = irq_out_reg;
   assign irq_oe  = irq_oe_reg;

endmodule : hpsc_serial_ctrl

/* hw/hpsc_sync2.sv */
// two flip-flop level synchroniser, any width
// assumes each bit is a level or a toggle that is independent of the others
`timescale 1ns/1ps
module hpsc_sync2
   import hpsc_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // crossing
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("hpsc_sync2: WIDTH must be at least 1");
      end
   end

   // first stage is read only by the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;

endmodule : hpsc_sync2

/* verification/hpsc_host_model.sv */
// host model for the four wire serial port
// assumes the bench calls frame and xfer; shift clock idles low
`timescale 1ns/1ps
module hpsc_host_model
(
   // serial pins
   output logic      shift_clk,
   output logic      select_n,
   output logic      serial_data_in,
   input  wire logic serial_data_out
);
   initial
   begin
      shift_clk = 1'b0;
      select_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // ---------
   // transfers
   // ---------
   task automatic frame(input logic open);
      #100;
      select_n = !open;
      #200;
   endtask : frame
   // the gap after each byte covers the slow reply path
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i--)
      begin
         serial_data_in = tx[i];
         #7.5 rx[i] = serial_data_out;
         shift_clk = 1'b1;
         #7.5 shift_clk = 1'b0;
      end
      serial_data_in = !serial_data_in;
      #300;
   endtask : xfer
endmodule : hpsc_host_model

/* verification/hpsc_serial_ctrl_sva.sv */
// checker on the serial control block ports
// assumes one sys_clk domain and an asynchronous active high rst
`timescale 1ns/1ps
module hpsc_serial_ctrl_sva
   import hpsc_pkg::*;
(
   // clock, reset and pins
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       hw_init_n,
   input wire logic       strap_latch,
   input wire logic       select_n,
   input wire logic       serial_data_out_oe,
   // register side, mode and interrupt
   input wire logic       reg_wr_en,
   input wire logic       reg_rd_en,
   input wire logic       fifo_ptr_inc,
   input wire hpsc_mode_e host_mode,
   input wire logic       mgmt_slave_en,
   input wire logic       irq_req,
   input wire logic       irq_active_high,
   input wire logic       irq_out,
   input wire logic       irq_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ------
   // checks
   // ------
   // eight cycles leave room for a byte that ends just before the rise
   sequence s_idle;
      select_n [*8];
   endsequence
   sequence s_quiet;
      (hw_init_n && $stable(strap_latch) && !$past(rst)) [*4];
   endsequence
   property p_oe_idle;
      s_idle |-> !serial_data_out_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("output driven while idle");
   property p_idle_quiet;
      s_idle |-> !(reg_wr_en || reg_rd_en || fifo_ptr_inc);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("access while idle");
   property p_wr_pulse;
      reg_wr_en |=> !reg_wr_en;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("long write strobe");
   property p_wr_mode;
      (reg_wr_en || reg_rd_en) |-> host_mode == HPSC_MODE_SERIAL;
   endproperty
   a_wr_mode: assert property (p_wr_mode)
      else $error("access outside serial mode");
   property p_mgmt;
      mgmt_slave_en == (host_mode == HPSC_MODE_NOHOST);
   endproperty
   a_mgmt: assert property (p_mgmt)
      else $error("slave flag wrong");
   property p_irq_low;
      !$past(rst) && !$past(irq_active_high) |-> !irq_out && irq_oe == $past(irq_req);
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("low irq wrong");
   property p_irq_high;
      !$past(rst) && $past(irq_active_high) |-> irq_oe && irq_out == $past(irq_req);
   endproperty
   a_irq_high: assert property (p_irq_high)
      else $error("high irq wrong");
   property p_mode_hold;
      s_quiet |=> $stable(host_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode moved after init");
endmodule : hpsc_serial_ctrl_sva

bind hpsc_serial_ctrl hpsc_serial_ctrl_sva u_sva (.*);

/* verification/hpsc_serial_ctrl_tb.sv */
// bench for the host port select and serial control block
// assumes hpsc_host_model as host and a register file kept here
`timescale 1ns/1ps
module hpsc_serial_ctrl_tb;
   import hpsc_pkg::*;
   logic        sys_clk, rst, hw_init_n, strap_wr, strap_rd, strap_sel, strap_latch;
   logic        indirect_addressing_select, shift_clk, select_n, serial_data_in;
   logic        serial_data_out, serial_data_out_oe, reg_wr_en, reg_rd_en, fifo_ptr_inc;
   logic        mgmt_slave_en, irq_req, irq_active_high, irq_out, irq_oe;
   logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, got_addr, got_data, rx;
   logic [31:0] seed;
   hpsc_mode_e  host_mode;
   int          n_errors, total_checks, n_wr, w, n_inc, n_rd, n_oe, i;
   hpsc_serial_ctrl DUT (.*);
   hpsc_host_model  host (.*);
   // -------
   // helpers
   // -------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   function automatic logic [7:0] rd_value(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction : rd_value
   function automatic logic [7:0] hdr_of(input int k);
      logic [7:0] t [5] = '{8'h40, 8'h48, 8'h43, 8'h41, 8'h49};
      return t[k % 5] | (k > 4 ? 8'h04 : 8'h00);
   endfunction : hdr_of
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic strap(input logic [3:0] pins, input hpsc_mode_e exp);
      @(posedge sys_clk);
      #1 hw_init_n = 1'b0;
      {strap_wr, strap_rd, strap_sel, strap_latch} = pins;
      repeat (6) @(posedge sys_clk);
      #1 hw_init_n = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 check(host_mode, exp);
      check(mgmt_slave_en, exp == HPSC_MODE_NOHOST);
   endtask : strap
   task automatic access(input logic [7:0] h, input logic [7:0] a, input logic [7:0] d,
                         input int nb);
      host.frame(1'b1);
      host.xfer(h, 8, rx);
      host.xfer(a, 8, rx);
      host.xfer(d, nb, rx);
      host.frame(1'b0);
   endtask : access
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // register file answers the cycle after the read strobe
   always @(posedge sys_clk)
   begin
      reg_rd_data <= #1 rd_value(reg_addr);
      if (reg_wr_en === 1'b1)
      begin
         got_addr = reg_addr;
         got_data = reg_wr_data;
         n_wr++;
      end
      n_inc += (fifo_ptr_inc === 1'b1);
      n_rd += (reg_rd_en === 1'b1);
      n_oe += (serial_data_out_oe === 1'b1);
   end
   initial
   begin
      #200000;
      n_errors++;
      give_verdict();
   end
   initial
   begin
      seed = 32'h0001_3E4D;
      {rst, hw_init_n, strap_wr, strap_rd, strap_sel, strap_latch} = 6'h3F;
      {indirect_addressing_select, irq_req, irq_active_high} = 3'h0;
      reg_rd_data = 8'h00;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      strap(4'hF, HPSC_MODE_STROBE);
      strap(4'hE, HPSC_MODE_NONMUX);
      strap_latch = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 check(host_mode, HPSC_MODE_MUX);
      strap(4'h0, HPSC_MODE_NOHOST);
      strap(4'h2, HPSC_MODE_SERIAL);
      strap_sel = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 check(host_mode, HPSC_MODE_SERIAL);
      $display("strap test done");
      for (int k = 0; k < 10; k++)
      begin
         seed = xorshift(seed);
         w = n_wr;
         access(hdr_of(k), {1'b0, seed[6:0]}, seed[15:8], 8);
         check(n_wr, w + 1);
         check(got_addr, {k > 4, seed[6:0]});
         check(got_data, seed[15:8]);
      end
      $display("write test done");
      w = n_wr;
      access(8'h42, 8'h05, 8'hA5, 8);
      access(8'h40, 8'h05, 8'hA5, 4);
      check(n_wr, w);
      $display("refusal test done");
      i = n_inc;
      access(8'h43, 8'h7A, 8'h3C, 8);
      access(8'h43, 8'h20, 8'h3C, 8);
      check(n_inc, i + 1);
      check(n_oe, 0);
      $display("fifo test done");
      for (int k = 0; k < 4; k++)
      begin
         seed = xorshift(seed);
         w = n_rd;
         access(hdr_of(k[0] + 5 * k[1]), {1'b1, seed[6:0]}, {1'b1, seed[6:0]}, 8);
         check(rx, rd_value({k[1], seed[6:0]}));
         check(n_rd, w + 1 + k[0]);
      end
      check(n_oe != 0, 1'b1);
      $display("read test done");
      for (int k = 0; k < 4; k++)
      begin
         @(posedge sys_clk);
         #1 {irq_active_high, irq_req} = k[1:0];
         repeat (3) @(posedge sys_clk);
         #1 check({irq_oe, irq_out}, k[1] ? {1'b1, k[0]} : {k[0], 1'b0});
      end
      $display("interrupt test done");
      @(posedge sys_clk);
      #1 rst = 1'b1;
      indirect_addressing_select = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'b0;
      strap(4'h2, HPSC_MODE_SERIAL);
      w = n_wr;
      access(8'h40, 8'h00, 8'h37, 8);
      access(8'h40, 8'h01, 8'hC9, 8);
      check(n_wr, w + 1);
      check(got_addr, 8'h37);
      check(got_data, 8'hC9);
      $display("indirect test done");
      give_verdict();
   end
endmodule : hpsc_serial_ctrl_tb
